// ===== return_stack_defines.svh
`ifndef RETURN_STACK_DEFINES_SVH
`define RETURN_STACK_DEFINES_SVH

// ----------------------------------------
// Geometry
// ----------------------------------------
`define RAS_DEPTH 31
`define RAS_PC_W 21
`define RAS_SP_W 5
`define RAS_UPPER_W 5
`define RAS_SP_EMPTY 5'h00
`define RAS_SP_LAST 5'h1F
`define RAS_SP_NEAR_FULL 5'h1E

// ----------------------------------------
// Pointer byte layout, reset PC and zero byte
// ----------------------------------------
`define RAS_FULL_BIT 7
`define RAS_UNF_BIT 6
`define RAS_PC_RESET 21'h000000
`define RAS_BYTE_ZERO 8'h00
`endif

// ===== return_stack_pkg.sv
`include "return_stack_defines.svh"
package return_stack_pkg;
    typedef logic [`RAS_PC_W-1:0] pc_t;
    typedef logic [`RAS_SP_W-1:0] sp_t;
    typedef logic [7:0] byte_t;

    typedef enum logic [1:0] {
        ACT_NONE,
        ACT_SW,
        ACT_PUSH,
        ACT_POP
    } action_e;

    typedef struct packed {
        logic [`RAS_DEPTH:1][`RAS_PC_W-1:0] mem;
        sp_t sp;
        logic full;
        logic unf;
        pc_t pop_pc;
        logic pop_valid;
        logic reset_req;
    } state_s;
endpackage : return_stack_pkg

// ===== return_address_stack.sv
`timescale 1ns/10ps
`include "return_stack_defines.svh"
module return_address_stack (
    input wire logic clk,
    input wire logic resetn,
    input wire logic por_resetn,
    input wire logic push,
    input wire return_stack_pkg::pc_t push_pc,
    input wire logic pop,
    input wire logic overflow_reset_enable,
    input wire logic sp_wr,
    input wire return_stack_pkg::byte_t sp_wdata,
    input wire logic upper_wr,
    input wire logic high_wr,
    input wire logic low_wr,
    input wire return_stack_pkg::byte_t tos_wdata,
    output return_stack_pkg::byte_t stack_pointer_reg,
    output return_stack_pkg::byte_t top_entry_upper,
    output return_stack_pkg::byte_t top_entry_high,
    output return_stack_pkg::byte_t top_entry_low,
    output logic stack_full_flag,
    output logic stack_underflow_flag,
    output return_stack_pkg::pc_t pop_pc,
    output logic pop_valid,
    output logic stack_reset_req
);
    import return_stack_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    state_s cur;
    state_s next_cur;
    action_e action;
    sp_t sp;
    pc_t top;
    logic sw_any;
    logic pop_taken;

    assign sp = cur.sp;
    assign pop_taken = (action == ACT_POP);
    assign sw_any = sp_wr | upper_wr | high_wr | low_wr;

    // Slot zero has no storage behind it
    assign top = (cur.sp == `RAS_SP_EMPTY) ? `RAS_PC_RESET : cur.mem[cur.sp];

    // Push beats pop if the sequencer ever asserts both
    // Nothing is taken while either reset is held
    always_comb
    begin
        if (!resetn || !por_resetn)
            action = ACT_NONE;
        else if (sw_any)
            action = ACT_SW;
        else if (push)
            action = ACT_PUSH;
        else if (pop)
            action = ACT_POP;
        else
            action = ACT_NONE;
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        next_cur = cur;
        next_cur.pop_valid = 1'b0;
        next_cur.reset_req = 1'b0;
        unique case (action)
            ACT_SW:
            begin
                if (cur.sp != `RAS_SP_EMPTY)
                begin
                    if (upper_wr)
                        next_cur.mem[cur.sp][20:16] = tos_wdata[`RAS_UPPER_W-1:0];
                    if (high_wr)
                        next_cur.mem[cur.sp][15:8] = tos_wdata;
                    if (low_wr)
                        next_cur.mem[cur.sp][7:0] = tos_wdata;
                end
                if (sp_wr)
                begin
                    next_cur.sp = sp_wdata[`RAS_SP_W-1:0];
                    next_cur.full = sp_wdata[`RAS_FULL_BIT];
                    next_cur.unf = sp_wdata[`RAS_UNF_BIT];
                end
            end
            ACT_PUSH:
            begin
                if (cur.sp != `RAS_SP_LAST)
                begin
                    next_cur.sp = cur.sp + 5'h01;
                    next_cur.mem[cur.sp + 5'h01] = push_pc;
                    if (cur.sp == `RAS_SP_NEAR_FULL)
                        next_cur.full = 1'b1;
                end
                else if (overflow_reset_enable)
                begin
                    next_cur.full = 1'b1;
                    next_cur.sp = `RAS_SP_EMPTY;
                    next_cur.reset_req = 1'b1;
                end
                else
                begin
                    next_cur.full = 1'b1;
                end
            end
            ACT_POP:
            begin
                // Only the PC sees the popped value, latches stay put
                next_cur.pop_valid = 1'b1;
                if (cur.sp != `RAS_SP_EMPTY)
                begin
                    next_cur.pop_pc = cur.mem[cur.sp];
                    next_cur.sp = cur.sp - 5'h01;
                end
                else
                begin
                    next_cur.pop_pc = `RAS_PC_RESET;
                    next_cur.unf = 1'b1;
                    next_cur.reset_req = overflow_reset_enable;
                end
            end
            ACT_NONE:
            begin
                next_cur.pop_valid = 1'b0;
            end
        endcase
        // Flags and entries survive a warm reset
        if (!por_resetn)
        begin
            next_cur = '0;
        end
        else if (!resetn)
        begin
            next_cur.sp = `RAS_SP_EMPTY;
            next_cur.pop_pc = `RAS_PC_RESET;
            next_cur.pop_valid = 1'b0;
            next_cur.reset_req = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        cur <= next_cur;
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign stack_pointer_reg = {cur.full, cur.unf, 1'b0, cur.sp};
    assign top_entry_upper = {3'h0, top[20:16]};
    assign top_entry_high = top[15:8];
    assign top_entry_low = top[7:0];
    assign stack_full_flag = cur.full;
    assign stack_underflow_flag = cur.unf;
    assign pop_pc = cur.pop_pc;
    assign pop_valid = cur.pop_valid;
    assign stack_reset_req = cur.reset_req;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn || !por_resetn);

    sequence s_push_ok;
        !sw_any && push && (sp != `RAS_SP_LAST);
    endsequence

    sequence s_pop_ok;
        !sw_any && !push && pop && (sp != `RAS_SP_EMPTY);
    endsequence

    sequence s_push_over;
        !sw_any && push && (sp == `RAS_SP_LAST);
    endsequence

    property p_push_inc;
        s_push_ok |=> (sp == $past(sp) + 5'h01);
    endproperty
    a_push_inc: assert property (p_push_inc)
        else $error("push did not advance pointer");

    property p_push_store;
        s_push_ok |=> (top == $past(push_pc)) && !pop_valid;
    endproperty
    a_push_store: assert property (p_push_store)
        else $error("pushed value not on top");

    property p_pop_dec;
        s_pop_ok |=> ((sp == $past(sp) - 5'h01) && pop_valid)
            ##1 (pop_valid == $past(pop_taken));
    endproperty
    a_pop_dec: assert property (p_pop_dec)
        else $error("pop did not step pointer back");

    property p_pop_data;
        s_pop_ok |=> (pop_pc == $past(top));
    endproperty
    a_pop_data: assert property (p_pop_data)
        else $error("popped value wrong");

    property p_full_set;
        (!sw_any && push && sp == `RAS_SP_NEAR_FULL) |=> stack_full_flag && sp == `RAS_SP_LAST;
    endproperty
    a_full_set: assert property (p_full_set)
        else $error("full flag missing at last push");

    property p_ovf_reset;
        (s_push_over and overflow_reset_enable)
            |=> stack_full_flag && sp == `RAS_SP_EMPTY && stack_reset_req;
    endproperty
    a_ovf_reset: assert property (p_ovf_reset)
        else $error("overflow did not reset stack");

    property p_ovf_hold;
        (s_push_over and !overflow_reset_enable)
            |=> stack_full_flag && sp == `RAS_SP_LAST && !stack_reset_req;
    endproperty
    a_ovf_hold: assert property (p_ovf_hold)
        else $error("overflow push not ignored");

    property p_unf;
        (!sw_any && !push && pop && sp == `RAS_SP_EMPTY)
            |=> stack_underflow_flag && pop_pc == `RAS_PC_RESET && sp == `RAS_SP_EMPTY;
    endproperty
    a_unf: assert property (p_unf)
        else $error("empty pop handled wrong");

    property p_full_sticky;
        @(posedge clk) disable iff (!por_resetn)
        (stack_full_flag && !sp_wr) |=> stack_full_flag;
    endproperty
    a_full_sticky: assert property (p_full_sticky)
        else $error("full flag dropped without clear");

    property p_unf_sticky;
        @(posedge clk) disable iff (!por_resetn)
        (stack_underflow_flag && !sp_wr) |=> stack_underflow_flag;
    endproperty
    a_unf_sticky: assert property (p_unf_sticky)
        else $error("underflow flag dropped without clear");

    property p_warm_reset;
        @(posedge clk) disable iff (!por_resetn)
        !resetn |=> sp == `RAS_SP_EMPTY && !pop_valid;
    endproperty
    a_warm_reset: assert property (p_warm_reset)
        else $error("reset left pointer nonzero");

    property p_sw_first;
        sp_wr |=> (sp == $past(sp_wdata[4:0])) && !pop_valid;
    endproperty
    a_sw_first: assert property (p_sw_first)
        else $error("pointer write lost to stack op");

    property p_tos_low;
        (low_wr && sp != `RAS_SP_EMPTY && !sp_wr) |=> top_entry_low == $past(tos_wdata);
    endproperty
    a_tos_low: assert property (p_tos_low)
        else $error("top low byte write lost");

    sequence s_sw_only;
        sw_any && !sp_wr;
    endsequence

    sequence s_idle;
        !sw_any && !push && !pop;
    endsequence

    sequence s_pop_empty;
        !sw_any && !push && pop && (sp == `RAS_SP_EMPTY);
    endsequence

    property p_sw_drops_ops;
        sw_any |=> !pop_valid && !stack_reset_req;
    endproperty
    a_sw_drops_ops: assert property (p_sw_drops_ops)
        else $error("stack event taken beside software write");

    property p_tos_keeps_sp;
        s_sw_only
            |=> $stable(sp) && $stable(stack_full_flag) && $stable(stack_underflow_flag);
    endproperty
    a_tos_keeps_sp: assert property (p_tos_keeps_sp)
        else $error("top write disturbed pointer byte");

    property p_idle_hold;
        s_idle |=> $stable(sp) && $stable(pop_pc) && !pop_valid && !stack_reset_req;
    endproperty
    a_idle_hold: assert property (p_idle_hold)
        else $error("stack moved without request");

    property p_pop_keeps_entries;
        s_pop_ok |=> $stable(cur.mem);
    endproperty
    a_pop_keeps_entries: assert property (p_pop_keeps_entries)
        else $error("pop altered stored entries");

    property p_unf_req;
        (s_pop_empty and overflow_reset_enable) |=> stack_reset_req && pop_valid;
    endproperty
    a_unf_req: assert property (p_unf_req)
        else $error("underflow did not request reset");

    property p_empty_top;
        (sp == `RAS_SP_EMPTY)
            |-> {top_entry_upper, top_entry_high, top_entry_low} == 24'h000000;
    endproperty
    a_empty_top: assert property (p_empty_top)
        else $error("empty stack shows nonzero top");

endmodule : return_address_stack

// ===== ret_core_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// Core sequencer model
// ----------------------------------------
module ret_core_model (
    input wire logic req_push,
    input wire logic req_pop,
    input wire logic hold,
    input wire return_stack_pkg::pc_t req_pc,
    output logic push,
    output logic pop,
    output return_stack_pkg::pc_t push_pc
);
    import return_stack_pkg::*;
    // Masked interrupts keep the core off the stack during top access
    assign push = req_push & ~hold;
    // One stack event per cycle; a call wins over a return
    assign pop = req_pop & ~hold & ~req_push;
    assign push_pc = req_pc;
endmodule : ret_core_model

// ===== return_address_stack_tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module return_address_stack_tb;
    import return_stack_pkg::*;
    logic clk = 0, resetn = 0, por_resetn = 0, rq_push = 0, rq_pop = 0, hold = 0, en = 0;
    logic sp_wr = 0, upper_wr = 0, high_wr = 0, low_wr = 0, push, pop, full, unf, pv, rr;
    pc_t rq_pc = '0, push_pc, pop_pc, m_ppc, mem[1:31];
    byte_t sp_wdata = '0, tos_wdata = '0, spr, tu, th, tl;
    sp_t sp;
    logic m_full, m_unf, m_pv, m_rr;
    int fail_count = 0, comparisons = 0;
    logic [31:0] r;
    initial forever #2 clk = ~clk;
    ret_core_model ret_core_model_i (.req_push(rq_push), .req_pop(rq_pop), .hold(hold),
        .req_pc(rq_pc), .push(push), .pop(pop), .push_pc(push_pc));
    return_address_stack return_address_stack_i (.clk(clk), .resetn(resetn),
        .por_resetn(por_resetn), .push(push), .push_pc(push_pc), .pop(pop),
        .overflow_reset_enable(en), .sp_wr(sp_wr), .sp_wdata(sp_wdata), .upper_wr(upper_wr),
        .high_wr(high_wr), .low_wr(low_wr), .tos_wdata(tos_wdata), .stack_pointer_reg(spr),
        .top_entry_upper(tu), .top_entry_high(th), .top_entry_low(tl), .stack_full_flag(full),
        .stack_underflow_flag(unf), .pop_pc(pop_pc), .pop_valid(pv), .stack_reset_req(rr));
    // ----------------------------------------
    // Expectation
    // ----------------------------------------
    function automatic pc_t top_of();
        return (sp == 5'h00) ? 21'h000000 : mem[sp];
    endfunction : top_of
    task automatic tick();
        pc_t t;
        @(posedge clk);
        m_pv = 0;
        m_rr = 0;
        if (!por_resetn)
        begin
            sp = 0; m_full = 0; m_unf = 0; m_ppc = 0;
            foreach (mem[i]) mem[i] = '0;
        end
        else if (!resetn)
        begin
            sp = 0; m_ppc = 0;
        end
        else if (sp_wr | upper_wr | high_wr | low_wr)
        begin
            // Top writes address the old pointer
            if (sp != 5'h00 && upper_wr) mem[sp][20:16] = tos_wdata[4:0];
            if (sp != 5'h00 && high_wr) mem[sp][15:8] = tos_wdata;
            if (sp != 5'h00 && low_wr) mem[sp][7:0] = tos_wdata;
            if (sp_wr)
            begin
                sp = sp_wdata[4:0]; m_full = sp_wdata[7]; m_unf = sp_wdata[6];
            end
        end
        else if (push)
        begin
            if (sp == 5'h1F)
            begin
                m_full = 1; m_rr = en;
                if (en) sp = 0;
            end
            else
            begin
                sp++; mem[sp] = push_pc;
                if (sp == 5'h1F) m_full = 1;
            end
        end
        else if (pop)
        begin
            m_pv = 1; m_ppc = top_of();
            if (sp == 5'h00)
            begin
                m_unf = 1; m_rr = en;
            end
            else sp--;
        end
        @(negedge clk);
        t = top_of();
        `CHK(spr, {m_full, m_unf, 1'b0, sp})
        `CHK({tu, th, tl}, {3'h0, t})
        `CHK(full, m_full)
        `CHK(unf, m_unf)
        `CHK(pv, m_pv)
        `CHK(pop_pc, m_ppc)
        `CHK(rr, m_rr)
    endtask : tick
    task automatic done_test(string s);
        $display("test %s done", s);
    endtask : done_test
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : stop_test
    initial
    begin
        repeat (5000) @(posedge clk);
        fail_count++;
        stop_test();
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial
    begin
        void'($urandom(32'h0d7bb3b9));
        repeat (8) tick();
        {resetn, por_resetn} = 2'h3;
        done_test("reset");
        rq_push = 1;
        repeat (32)
        begin
            rq_pc = pc_t'($urandom);
            tick();
        end
        rq_push = 0;
        rq_pop = 1;
        repeat (33) tick();
        done_test("fill_drain");
        // Collisions with software writes are left unmasked on purpose
        repeat (400)
        begin
            r = $urandom;
            {rq_pop, rq_push, hold, en} = r[3:0];
            rq_pc = pc_t'($urandom);
            sp_wdata = byte_t'($urandom);
            tos_wdata = byte_t'($urandom);
            {sp_wr, upper_wr, high_wr, low_wr} = (r[6:4] < 3'h4) ? 4'h8 >> r[5:4] : 4'h0;
            tick();
        end
        done_test("random");
        {upper_wr, high_wr, low_wr, rq_push, rq_pop, hold} = '0;
        sp_wr = 1;
        sp_wdata = 8'hC5;
        tick();
        sp_wr = 0;
        resetn = 0;
        tick();
        resetn = 1;
        tick();
        `CHK(spr, 8'hC0)
        sp_wr = 1;
        sp_wdata = 8'h1E;
        en = 1;
        tick();
        sp_wr = 0;
        rq_push = 1;
        repeat (2) tick();
        `CHK(rr, 1'b1)
        rq_push = 0;
        rq_pop = 1;
        tick();
        `CHK(rr, 1'b1)
        rq_pop = 0;
        por_resetn = 0;
        tick();
        por_resetn = 1;
        tick();
        `CHK(spr, 8'h00)
        done_test("overflow_reset");
        stop_test();
    end
endmodule : return_address_stack_tb
